// *** rtl/dkrt_timer.sv ***
/*
 * dual key reset timer top: key qualification, delay and release timing,
 * open-drain active-low reset and push-pull active-high reset.
 * assumes key and factory pins are synchronous to clock_i.
 */
`default_nettype none
`include "dkrt_params.svh"

module dkrt_timer #(
    parameter logic [1:0] VARIANT = `DKRT_VAR_Q,
    parameter logic [`DKRT_CNT_W-1:0] DELAY_CYC =
        (VARIANT == `DKRT_VAR_R) ? `DKRT_CNT_W'(`DKRT_DLY_R_MS * `DKRT_CYC_PER_MS) :
        (VARIANT == `DKRT_VAR_T) ? `DKRT_CNT_W'(`DKRT_DLY_T_MS * `DKRT_CYC_PER_MS) :
                                   `DKRT_CNT_W'(`DKRT_DLY_Q_MS * `DKRT_CYC_PER_MS),
    parameter logic [`DKRT_CNT_W-1:0] RELEASE_CYC =
        (VARIANT == `DKRT_VAR_R) ? `DKRT_CNT_W'(`DKRT_REL_R_US * `DKRT_CYC_PER_US) :
        (VARIANT == `DKRT_VAR_T) ? `DKRT_CNT_W'(`DKRT_REL_T_US * `DKRT_CYC_PER_US) :
                                   `DKRT_CNT_W'(`DKRT_REL_Q_US * `DKRT_CYC_PER_US)
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // key inputs, active low
    input wire logic key_input_a_n_i,
    input wire logic key_input_b_n_i,
    // factory pins, expected at ground
    input wire logic factory_pin_a_i,
    input wire logic factory_pin_b_i,
    // open-drain reset: pin level is always low, enable pulls it
    output logic reset_out_n_o,
    output logic reset_out_n_oe_o,
    // push-pull reset
    output logic reset_out_high_o,
    // state seen from outside
    output logic delay_running_o
);
    dkrt_pkg::dkrt_state_t state_ff;
    dkrt_pkg::dkrt_state_t nxt_state;
    dkrt_pkg::dkrt_keys_t keys;
    dkrt_pkg::dkrt_resets_t resets_ff;
    dkrt_pkg::dkrt_resets_t nxt_resets;
    logic running_ff;
    wire logic both_low;
    wire logic delay_done;
    wire logic release_done;
    wire logic in_delay;
    wire logic in_assert;

    assign keys = '{key_a_n: key_input_a_n_i, key_b_n: key_input_b_n_i};
    // one-key systems tie the spare key low, so this still tracks the used key
    assign both_low = ~keys.key_a_n & ~keys.key_b_n;
    assign in_delay = (state_ff == dkrt_pkg::DKRT_DELAY);
    assign in_assert = (state_ff == dkrt_pkg::DKRT_ASSERT);

    // counters clear whenever their state is left, so an abort restarts from zero
    dkrt_counter u_delay_cnt (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .run_i(in_delay & both_low),
        .limit_i(DELAY_CYC),
        .done_o(delay_done)
    );

    dkrt_counter u_release_cnt (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .run_i(in_assert & both_low),
        .limit_i(RELEASE_CYC),
        .done_o(release_done)
    );

    // factory pins are not used: only the normal timing is built, a limitation
    // of this model compared to a test-mode part
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            dkrt_pkg::DKRT_IDLE: begin
                if (both_low) begin
                    nxt_state = dkrt_pkg::DKRT_DELAY;
                end
            end
            dkrt_pkg::DKRT_DELAY: begin
                if (!both_low) begin
                    nxt_state = dkrt_pkg::DKRT_IDLE;
                end else if (delay_done) begin
                    nxt_state = dkrt_pkg::DKRT_ASSERT;
                end
            end
            dkrt_pkg::DKRT_ASSERT: begin
                if (!both_low) begin
                    nxt_state = dkrt_pkg::DKRT_IDLE;
                end else if (release_done) begin
                    nxt_state = dkrt_pkg::DKRT_HOLD;
                end
            end
            dkrt_pkg::DKRT_HOLD: begin
                if (!both_low) begin
                    nxt_state = dkrt_pkg::DKRT_IDLE;
                end
            end
            default: begin
                nxt_state = dkrt_pkg::DKRT_IDLE;
            end
        endcase
    end

    // outputs follow the next state so they move on the same edge as the state
    wire logic nxt_asserted;
    assign nxt_asserted = (nxt_state == dkrt_pkg::DKRT_ASSERT);
    assign nxt_resets = '{reset_low_oe: nxt_asserted, reset_out_high: nxt_asserted};

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state_ff <= dkrt_pkg::DKRT_IDLE;
            resets_ff <= '0;
            running_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            resets_ff <= nxt_resets;
            running_ff <= (nxt_state == dkrt_pkg::DKRT_DELAY);
        end
    end

    // open drain: data held low, only the enable moves
    assign reset_out_n_o = 1'b0;
    assign reset_out_n_oe_o = resets_ff.reset_low_oe;
    assign reset_out_high_o = resets_ff.reset_out_high;
    assign delay_running_o = running_ff;

    wire logic unused_ok;
    assign unused_ok = factory_pin_a_i | factory_pin_b_i;
endmodule : dkrt_timer

`default_nettype wire

// *** rtl/dkrt_params.svh ***
/*
 * constants for the dual key reset timer: variant codes and timing counts.
 * assumes a 100 MHz clock; included by bare name from the rtl files.
 */
// How it works
// - The delay count starts only while both active-low key inputs are low together.
// - Reset is asserted once the delay count has run its full length with both keys held low.
// - The delay is 7.5 s, 10 s or 3.0 s by variant, well within the ten percent tolerance.
// - The variant is a build-time parameter, so the delay cannot be changed in operation.
// - Either key going high during the delay stops the count and no reset is asserted.
// - After an abort the count restarts from zero once both keys are low again.
// - An asserted reset is released automatically once the release interval has elapsed.
// - The release interval is 0.234 s, 0.313 s or 0.1875 s matching the variant.
// - Either key going high while reset is asserted releases it at once.
// - The primary reset is active low and only ever pulls toward ground.
// - The second output is an active-high push-pull reset with the same timing.
`ifndef DKRT_PARAMS_SVH
`define DKRT_PARAMS_SVH

`define DKRT_CLK_HZ 100000000
`define DKRT_VAR_Q 2'h0
`define DKRT_VAR_R 2'h1
`define DKRT_VAR_T 2'h2
// delay times in milliseconds
`define DKRT_DLY_Q_MS 7500
`define DKRT_DLY_R_MS 10000
`define DKRT_DLY_T_MS 3000
// release times in microseconds, kept exact so no rounding creeps in
`define DKRT_REL_Q_US 234000
`define DKRT_REL_R_US 313000
`define DKRT_REL_T_US 187500
`define DKRT_CYC_PER_MS (`DKRT_CLK_HZ / 1000)
`define DKRT_CYC_PER_US (`DKRT_CLK_HZ / 1000000)
`define DKRT_CNT_W 32

`endif

// *** rtl/dkrt_pkg.sv ***
/*
 * types for the dual key reset timer.
 * assumes dkrt_params.svh is on the include path.
 */
`default_nettype none
`include "dkrt_params.svh"

package dkrt_pkg;

    typedef enum logic [3:0] {
        DKRT_IDLE = 4'h1,
        DKRT_DELAY = 4'h2,
        DKRT_ASSERT = 4'h4,
        DKRT_HOLD = 4'h8
    } dkrt_state_t;

    typedef struct packed {
        logic key_a_n;
        logic key_b_n;
    } dkrt_keys_t;

    typedef struct packed {
        logic reset_low_oe;
        logic reset_out_high;
    } dkrt_resets_t;

endpackage : dkrt_pkg

`default_nettype wire

// *** rtl/dkrt_counter.sv ***
/*
 * interval counter: counts while run is high, flags when limit is reached.
 * assumes a synchronous active-high reset and a limit held steady.
 */
`default_nettype none
`include "dkrt_params.svh"

module dkrt_counter (
    // clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // control
    input wire logic run_i,
    input wire logic [`DKRT_CNT_W-1:0] limit_i,
    // status
    output logic done_o
);
    logic [`DKRT_CNT_W-1:0] count_ff;
    logic [`DKRT_CNT_W-1:0] nxt_count;
    logic done_ff;
    wire logic at_limit;

    // done is registered, so it rises the cycle after the count reaches limit minus one, where the count holds
    assign at_limit = (count_ff + `DKRT_CNT_W'h1) >= limit_i;
    assign nxt_count = run_i ? (at_limit ? count_ff : count_ff + `DKRT_CNT_W'h1) : '0;

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            count_ff <= '0;
            done_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            done_ff <= run_i & at_limit;
        end
    end

    assign done_o = done_ff;
endmodule : dkrt_counter

`default_nettype wire

// *** verif/dkrt_timer_asserts.sv ***
/* port checker for dkrt_timer, with its bind.
   assumes one clock and the short counts the bench passes. */
`default_nettype none
`include "dkrt_params.svh"
module dkrt_timer_chk #(
    parameter logic [`DKRT_CNT_W-1:0] DELAY_CYC = 20,
    parameter logic [`DKRT_CNT_W-1:0] RELEASE_CYC = 8
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // keys
    input wire logic key_input_a_n_i,
    input wire logic key_input_b_n_i,
    // outputs
    input wire logic reset_out_n_oe_o,
    input wire logic reset_out_high_o,
    input wire logic delay_running_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int D = int'(DELAY_CYC);
    localparam int R = int'(RELEASE_CYC);
    wire logic lo = !key_input_a_n_i && !key_input_b_n_i;
    int lo_cnt;
    int on_cnt;
    always_ff @(posedge clock_i) begin
        lo_cnt <= (srst_i || !lo) ? 0 : lo_cnt + 1;
        on_cnt <= (srst_i || !reset_out_n_oe_o) ? 0 : on_cnt + 1;
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (srst_i);
    sequence s_rise; lo && !$past(lo); endsequence
    sequence s_auto_off; $fell(reset_out_n_oe_o) && $past(lo) ##0 lo[*4]; endsequence
    property p_start; s_rise |=> delay_running_o; endproperty
    a_start: assert property (p_start) else $error("delay did not start");
    property p_abort; delay_running_o && !lo |=> !delay_running_o && !reset_out_n_oe_o; endproperty
    a_abort: assert property (p_abort) else $error("delay not stopped");
    property p_early; reset_out_n_oe_o && !lo |=> !reset_out_n_oe_o; endproperty
    a_early: assert property (p_early) else $error("reset kept after key high");
    property p_not_early; reset_out_n_oe_o |-> lo_cnt >= D; endproperty
    a_not_early: assert property (p_not_early) else $error("reset too soon");
    property p_time; $rose(reset_out_n_oe_o) |-> lo_cnt <= D + 3; endproperty
    a_time: assert property (p_time) else $error("reset too late");
    property p_auto; reset_out_n_oe_o |-> on_cnt <= R + 2; endproperty
    a_auto: assert property (p_auto) else $error("reset held too long");
    property p_min; $fell(reset_out_n_oe_o) && $past(lo) |-> $past(on_cnt) >= R - 1; endproperty
    a_min: assert property (p_min) else $error("release too short");
    property p_pp; reset_out_high_o == reset_out_n_oe_o; endproperty
    a_pp: assert property (p_pp) else $error("outputs differ");
    property p_hold; s_auto_off |-> !delay_running_o && !reset_out_n_oe_o; endproperty
    a_hold: assert property (p_hold) else $error("restart without key high");
endmodule : dkrt_timer_chk
bind dkrt_timer dkrt_timer_chk #(.DELAY_CYC(DELAY_CYC), .RELEASE_CYC(RELEASE_CYC)) i_chk (
    .clock_i(clock_i), .srst_i(srst_i), .key_input_a_n_i(key_input_a_n_i), .key_input_b_n_i(key_input_b_n_i),
    .reset_out_n_oe_o(reset_out_n_oe_o), .reset_out_high_o(reset_out_high_o), .delay_running_o(delay_running_o));
`default_nettype wire

// *** verif/dkrt_line_model.sv ***
/* reset target side: open-drain line with a pull-up.
   assumes the timer drives only the enable toward ground. */
`default_nettype none
module dkrt_line_model (
    // open-drain pin
    input wire logic od_data_i,
    input wire logic od_oe_i,
    // level seen by the target
    output logic line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    assign line_o = od_oe_i ? od_data_i : 1'b1; // pull-up owns the high level
endmodule : dkrt_line_model
`default_nettype wire

// *** verif/dkrt_timer_bench.sv ***
/* self-checking bench for dkrt_timer with short counts.
   assumes the bound checker and the line model are built too. */
`default_nettype none
`include "dkrt_params.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module dkrt_timer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int D = 20;
    localparam int R = 8;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic ka = 1'b1;
    logic kb = 1'b1;
    logic od, oe, hi, run;
    wire logic line;
    int bad_count = 0;
    int tests_run = 0;
    int n;
    logic [2:0] rows [4] = '{3'b110, 3'b010, 3'b100, 3'b001};
    dkrt_timer #(.VARIANT(`DKRT_VAR_T), .DELAY_CYC(`DKRT_CNT_W'(D)), .RELEASE_CYC(`DKRT_CNT_W'(R))) i_dut (
        .clock_i(clock_i), .srst_i(srst_i), .key_input_a_n_i(ka), .key_input_b_n_i(kb),
        .factory_pin_a_i(1'b0), .factory_pin_b_i(1'b0),
        .reset_out_n_o(od), .reset_out_n_oe_o(oe), .reset_out_high_o(hi), .delay_running_o(run));
    dkrt_line_model i_line (.od_data_i(od), .od_oe_i(oe), .line_o(line));
    initial forever #5 clock_i = ~clock_i;
    task automatic cyc(input int k);
        repeat (k) @(negedge clock_i);
    endtask : cyc
    task automatic keys(input logic a, input logic b);
        @(negedge clock_i);
        ka = a;
        kb = b;
    endtask : keys
    task automatic wrap_up;
        $display("tests %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    // bounded so a stuck line ends the run
    task automatic wait_line(input logic lvl, input int lim);
        n = 0;
        while (line !== lvl && n < lim) begin
            @(negedge clock_i);
            n++;
        end
        // judged on the level, so a line that arrives on the last step still passes
        if (line !== lvl) begin
            `CHK("line wait", lvl, line)
            wrap_up();
        end
    endtask : wait_line
    initial begin
        cyc(4);
        `CHK("line in reset", 1'b1, line)
        srst_i = 0;
        foreach (rows[i]) begin
            keys(rows[i][2], rows[i][1]);
            cyc(2);
            `CHK("running", rows[i][0], run)
            keys(1, 1);
        end
        $display("table done");
        keys(0, 0);
        wait_line(0, D + 5);
        `CHK("delay", 1'b1, n >= D && n <= D + 3)
        `CHK("push-pull", 1'b1, hi)
        wait_line(1, R + 5);
        `CHK("release", 1'b1, n >= R - 1 && n <= R + 3)
        cyc(10);
        `CHK("stay idle", 1'b0, run | oe)
        $display("auto release done");
        keys(1, 1);
        keys(0, 0);
        cyc(D - 2);
        keys(0, 1);
        cyc(2);
        `CHK("abort", 1'b0, run | oe)
        keys(0, 0);
        cyc(D - 2);
        `CHK("restart", 1'b1, line)
        wait_line(0, 8);
        `CHK("restart delay", 1'b1, n + D - 2 >= D && n + D - 2 <= D + 3)
        keys(1, 0);
        cyc(1);
        `CHK("key release", 1'b1, line)
        keys(0, 0);
        wait_line(0, D + 5);
        `CHK("one key", 1'b1, n >= D && n <= D + 3)
        $display("abort and single key done");
        srst_i = 1;
        cyc(4);
        `CHK("reset mid-run", 1'b1, line)
        srst_i = 0;
        cyc(1);
        // keys still low, so the first edge after release starts a fresh delay
        `CHK("run after reset", 1'b1, run)
        wait_line(0, D + 5);
        `CHK("delay after reset", 1'b1, n + 1 >= D && n + 1 <= D + 3)
        $display("mid-run reset done");
        wrap_up();
    end
endmodule : dkrt_timer_bench
`default_nettype wire
